//--- rtl/psf_consts.vh
`ifndef PSF_CONSTS_VH
`define PSF_CONSTS_VH
// ----------------------------------------
// timing figures, ns at a 50 ns clock
// ----------------------------------------
`define PSF_CLK_NS 50
`define PSF_OC_TURNOFF_NS 100
`define PSF_SHORT_WINDOW_NS 100
`define PSF_SC_RESET_LOW_NS 400000
`define PSF_IDM_BLANK_NS 200
// ----------------------------------------
// register map
// ----------------------------------------
`define PSF_REG_CTRL 4'h0
`define PSF_REG_STATUS 4'h4
`define PSF_REG_INPUTS 4'h8
// control bit positions
`define PSF_CTRL_SC_CLEAR 0
`define PSF_CTRL_FORCE_OFF 1
// status bit positions
`define PSF_ST_OC 0
`define PSF_ST_SC 1
`define PSF_ST_FET_OT 2
`define PSF_ST_DRV_OT 3
`define PSF_ST_SUPPLY_LOW_LOCKOUT 4
`define PSF_ST_STARTING 5
`define PSF_ST_COMBINED 6
`define PSF_ST_FET_ON 7
`define PSF_ST_SLOW_OFF 8
`define PSF_ST_IDM 9
`define PSF_ST_AUX_EN 10
// bus responses
`define PSF_RESP_OKAY 2'h0
`define PSF_RESP_SLVERR 2'h2
// diode emulation states
`define PSF_IDM_BLANK 2'h1
`define PSF_IDM_WATCH 2'h2
`define PSF_IDM_CONDUCT 2'h3
`endif

//--- rtl/psf_sync.v
`timescale 1ns/100ps
`include "psf_consts.vh"
// ----------------------------------------
// two-flop synchroniser, one per bit
// ----------------------------------------
module psf_sync #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] d,
    output wire [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta; // first stage, read only by stage two
    reg [WIDTH-1:0] sync; // second stage
    // reset to zero; callers invert any pin that idles high
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {WIDTH{1'b0}};
            sync <= {WIDTH{1'b0}};
        end else begin
            meta <= d;
            sync <= meta;
        end
    end
    assign q = sync;
endmodule

//--- rtl/psf_fault_logic.v
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "psf_consts.vh"
// How it works
// RULE1: overcurrent turns FET off, alarm low after delay
// RULE2: overcurrent clears when gate command goes low
// RULE3: delayed overcurrent versus short decides fault kind
// RULE4: short-circuit turn-off uses slowed drive
// RULE5: short latches FET off until long low
// RULE6: FET-die overheat enters diode emulation control
// RULE7: driver overheat kills aux rail, negative rail, FET
// RULE8: error low during any thermal shutdown
// RULE9: thermal states clear with hysteresis, auto resume
// RULE10: driver cools first, diode emulation resumes
// RULE11: supply low stops switching, error low
// RULE12: rails enable on lockout release rising edge
// RULE13: status pair encodes normal, fault, overcurrent, short
// RULE14: status outputs are push-pull, always driven; the alarm pin is released until the strap is sampled and while strapped
// RULE15: error low at start until series FET on
// RULE16: open slew pin holds error low
// RULE17: alarm grounded at power-up, error reports all
// RULE18: protection acts regardless of status observation
// RULE19: gate falling edge in emulation blanks, FET off
// RULE20: emulation toggles on drain polarity alone
// RULE21: latch release timer restarts on gate rise
module psf_fault_logic #(
    parameter SC_RESET_LOW_NS = `PSF_SC_RESET_LOW_NS
) (
    input wire CLK,
    input wire RST_N,
    // converter-side pins and analogue comparators, all asynchronous
    input wire GATE_COMMAND,
    input wire OC_DETECT,
    input wire SC_DETECT,
    input wire FET_OT_HOT,
    input wire DRV_OT_HOT,
    input wire SUPPLY_OK,
    input wire SLEW_OPEN,
    input wire SERIES_FET_ON,
    input wire DRAIN_NEGATIVE,
    input wire FIRST_QUADRANT,
    input wire ALARM_PIN_IN,
    // FET drive and rails
    output reg FET_ON,
    output reg SLOW_TURNOFF,
    output reg AUX_5V_RAIL_EN,
    output reg NEGATIVE_RAIL_EN,
    // status pins, push-pull
    output reg ERROR_REPORT_N,
    output reg CURRENT_ALARM_N,
    output wire CURRENT_ALARM_OE,
    // AXI4-Lite slave
    input wire [3:0] AWADDR,
    input wire AWVALID,
    output wire AWREADY,
    input wire [31:0] WDATA,
    input wire [3:0] WSTRB,
    input wire WVALID,
    output wire WREADY,
    output reg [1:0] BRESP,
    output reg BVALID,
    input wire BREADY,
    input wire [3:0] ARADDR,
    input wire ARVALID,
    output wire ARREADY,
    output reg [31:0] RDATA,
    output reg [1:0] RRESP,
    output reg RVALID,
    input wire RREADY
);
    // ----------------------------------------
    // derived cycle counts
    // ----------------------------------------
    localparam OC_DLY = (`PSF_OC_TURNOFF_NS + `PSF_CLK_NS - 1) / `PSF_CLK_NS;
    localparam WIN_DLY = (`PSF_SHORT_WINDOW_NS + `PSF_CLK_NS - 1) / `PSF_CLK_NS;
    localparam BLANK_CYC = (`PSF_IDM_BLANK_NS + `PSF_CLK_NS - 1) / `PSF_CLK_NS;
    localparam RST_CYC = (SC_RESET_LOW_NS + `PSF_CLK_NS - 1) / `PSF_CLK_NS;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    wire [10:0] raw; // pins idling high are inverted so reset reads idle
    wire [10:0] syn; // synchronised copies
    assign raw = {GATE_COMMAND, OC_DETECT, SC_DETECT, FET_OT_HOT, DRV_OT_HOT,
                  ~SUPPLY_OK, SLEW_OPEN, SERIES_FET_ON, DRAIN_NEGATIVE,
                  FIRST_QUADRANT, ~ALARM_PIN_IN};
    psf_sync #(.WIDTH(11)) u_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .d(raw),
        .q(syn)
    );
    wire gate = syn[10];
    wire oc_det = syn[9];
    wire sc_det = syn[8];
    wire fet_hot = syn[7]; // comparator carries its own hysteresis, see RULE9
    wire drv_hot = syn[6];
    wire supply_low = syn[5];
    wire slew_open = syn[4];
    wire series_on = syn[3];
    wire drain_neg = syn[2];
    wire first_q = syn[1];
    wire alarm_grounded = syn[0];

    // ----------------------------------------
    // control register
    // ----------------------------------------
    reg [1:0] ctrl; // sc_clear pulse bit and force-off
    wire sw_sc_clear;
    wire force_off = ctrl[`PSF_CTRL_FORCE_OFF];
    assign sw_sc_clear = ctrl[`PSF_CTRL_SC_CLEAR];

    // ----------------------------------------
    // overcurrent and short discrimination
    // ----------------------------------------
    reg [7:0] oc_cnt; // overcurrent age, saturating
    reg oc_flag; // cycle-by-cycle overcurrent
    reg sc_latch; // latched short
    reg [31:0] low_cnt; // continuous gate-low time
    reg gate_d; // previous gate, for edges
    wire oc_win = (oc_cnt >= WIN_DLY[7:0]); // delayed overcurrent seen
    wire release_low = (low_cnt >= RST_CYC - 1);
    // overcurrent age, cleared when current falls or gate drops
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            oc_cnt <= 8'h00;
        end else if (!oc_det || !gate) begin
            oc_cnt <= 8'h00;
        end else if (oc_cnt != 8'hFF) begin
            oc_cnt <= oc_cnt + 8'h01;
        end
    end
    // overcurrent flag: a race lost to the short leaves it clear
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            oc_flag <= 1'b0;
        end else if (!gate) begin
            oc_flag <= 1'b0; // see RULE2
        end else if (oc_win && !sc_latch && !sc_det && oc_cnt >= OC_DLY[7:0]) begin
            oc_flag <= 1'b1; // see RULE1 see RULE3
        end
    end
    // short latch; the short wins if it arrives before the window ends
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sc_latch <= 1'b0;
        end else if (sc_det && !oc_win && !oc_flag) begin
            sc_latch <= 1'b1; // see RULE3 see RULE5
        end else if (release_low && !gate || sw_sc_clear) begin
            sc_latch <= 1'b0; // see RULE5
        end
    end
    // gate-low timer restarts on every gate rise
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            low_cnt <= 32'h0;
            gate_d <= 1'b0;
        end else begin
            gate_d <= gate;
            if (gate) begin
                low_cnt <= 32'h0; // see RULE21
            end else if (!release_low) begin
                low_cnt <= low_cnt + 32'h1;
            end
        end
    end
    // slowed turn-off held while the short latch stands
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SLOW_TURNOFF <= 1'b0;
        end else begin
            SLOW_TURNOFF <= sc_latch; // see RULE4
        end
    end

    // ----------------------------------------
    // supply lockout, start-up, rails
    // ----------------------------------------
    reg supply_low_d; // for release edge
    reg started; // series FET seen on
    // rails come up on lockout release, drop on driver overheat
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            supply_low_d <= 1'b1;
            AUX_5V_RAIL_EN <= 1'b0;
            NEGATIVE_RAIL_EN <= 1'b0;
            started <= 1'b0;
        end else begin
            supply_low_d <= supply_low;
            if (drv_hot || supply_low) begin
                AUX_5V_RAIL_EN <= 1'b0; // see RULE7
                NEGATIVE_RAIL_EN <= 1'b0;
            end else if (supply_low_d && !supply_low) begin
                AUX_5V_RAIL_EN <= 1'b1; // see RULE12
                NEGATIVE_RAIL_EN <= 1'b1;
            end else if (!drv_hot && !AUX_5V_RAIL_EN && !supply_low_d) begin
                AUX_5V_RAIL_EN <= 1'b1; // driver cooled, rails return, see RULE9
                NEGATIVE_RAIL_EN <= 1'b1;
            end
            if (supply_low) begin
                started <= 1'b0;
            end else if (series_on) begin
                started <= 1'b1; // see RULE15
            end
        end
    end

    // ----------------------------------------
    // diode emulation state machine
    // ----------------------------------------
    reg [1:0] idm_state; // blank, watch, conduct
    reg [1:0] next_idm_state;
    reg [7:0] blank_cnt; // blanking timer
    wire idm_mode = fet_hot && !drv_hot; // see RULE6 see RULE10
    wire gate_fall = gate_d && !gate;
    // next state; a gate fall always wins
    always @* begin
        next_idm_state = idm_state;
        case (idm_state)
            `PSF_IDM_BLANK: begin
                if (blank_cnt >= BLANK_CYC[7:0] - 8'h01) begin
                    next_idm_state = `PSF_IDM_WATCH; // see RULE19
                end
            end
            `PSF_IDM_WATCH: begin
                if (drain_neg) begin
                    next_idm_state = `PSF_IDM_CONDUCT; // see RULE20
                end
            end
            `PSF_IDM_CONDUCT: begin
                if (first_q) begin
                    next_idm_state = `PSF_IDM_WATCH; // see RULE20
                end
            end
            default: begin
                next_idm_state = `PSF_IDM_WATCH;
            end
        endcase
        if (gate_fall) begin
            next_idm_state = `PSF_IDM_BLANK; // see RULE19
        end
    end
    // entering emulation starts in the watch state
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            idm_state <= `PSF_IDM_WATCH;
            blank_cnt <= 8'h00;
        end else if (!idm_mode) begin
            idm_state <= `PSF_IDM_WATCH;
            blank_cnt <= 8'h00;
        end else begin
            idm_state <= next_idm_state;
            if (gate_fall) begin
                blank_cnt <= 8'h00; // every fall restarts a full blank, see RULE19
            end else if (idm_state == `PSF_IDM_BLANK) begin
                blank_cnt <= blank_cnt + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // FET drive; protection never depends on status pins
    // ----------------------------------------
    wire fet_block = supply_low || drv_hot || sc_latch || sc_det || oc_flag
                     || force_off || !started;
    // registered gate drive
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            FET_ON <= 1'b0;
        end else if (fet_block) begin
            FET_ON <= 1'b0; // see RULE1 see RULE5 see RULE7 see RULE11 see RULE18
        end else if (idm_mode) begin
            FET_ON <= (idm_state == `PSF_IDM_CONDUCT); // see RULE6
        end else begin
            FET_ON <= gate; // see RULE2
        end
    end

    // ----------------------------------------
    // status encoding
    // ----------------------------------------
    reg combined; // alarm pin strapped low at power-up
    reg strap_done; // strap sampled once
    // strap caught once the series FET is first seen on, from the pin's own level
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            combined <= 1'b0;
            strap_done <= 1'b0;
        end else if (!strap_done && started) begin
            combined <= alarm_grounded; // see RULE17
            strap_done <= 1'b1;
        end
    end
    wire gen_fault = supply_low || fet_hot || drv_hot || slew_open || !started;
    // sets both status pin levels every cycle; the alarm pin is driven only while CURRENT_ALARM_OE is high
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ERROR_REPORT_N <= 1'b0;
            CURRENT_ALARM_N <= 1'b1;
        end else begin
            // see RULE8 see RULE11 see RULE13 see RULE15 see RULE16
            ERROR_REPORT_N <= !(gen_fault || sc_latch || (combined && oc_flag));
            CURRENT_ALARM_N <= !(oc_flag || sc_latch); // see RULE13
        end
    end
    // released while strapped so the strap is not fought
    assign CURRENT_ALARM_OE = !(combined || !strap_done); // see RULE14 see RULE17

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    reg aw_held; // write address taken
    reg w_held; // write data taken
    reg [3:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    assign AWREADY = !aw_held && !BVALID;
    assign WREADY = !w_held && !BVALID;
    assign ARREADY = !RVALID;
    wire [31:0] status_word = {21'h0, AUX_5V_RAIL_EN, idm_mode, SLOW_TURNOFF, FET_ON,
                               combined, !started, supply_low, drv_hot, fet_hot,
                               sc_latch, oc_flag};
    // write path, both channels in either order
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            BVALID <= 1'b0;
            BRESP <= `PSF_RESP_OKAY;
            ctrl <= 2'h0;
        end else begin
            ctrl[`PSF_CTRL_SC_CLEAR] <= 1'b0; // clear bit self-clears
            if (AWVALID && AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_held <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            if (aw_held && w_held) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                BVALID <= 1'b1;
                if (aw_addr == `PSF_REG_CTRL) begin
                    BRESP <= `PSF_RESP_OKAY;
                    if (w_strb[0]) begin
                        ctrl <= w_data[1:0];
                    end
                end else if (aw_addr == `PSF_REG_STATUS || aw_addr == `PSF_REG_INPUTS) begin
                    BRESP <= `PSF_RESP_OKAY; // read-only, write ignored
                end else begin
                    BRESP <= `PSF_RESP_SLVERR;
                end
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end
    // read path, one cycle after address
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RVALID <= 1'b0;
            RDATA <= 32'h0;
            RRESP <= `PSF_RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP <= `PSF_RESP_OKAY;
            case (ARADDR)
                `PSF_REG_CTRL: RDATA <= {30'h0, ctrl};
                `PSF_REG_STATUS: RDATA <= status_word;
                `PSF_REG_INPUTS: RDATA <= {21'h0, syn};
                default: begin
                    RDATA <= 32'h0;
                    RRESP <= `PSF_RESP_SLVERR;
                end
            endcase
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end
    end
endmodule

//--- sim/psf_fault_logic_assertions.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checks for the fault logic
// ----------------------------------------
module psf_fault_logic_assertions (
    input wire CLK,
    input wire RST_N,
    input wire GATE_COMMAND,
    input wire OC_DETECT,
    input wire SC_DETECT,
    input wire FET_OT_HOT,
    input wire DRV_OT_HOT,
    input wire SUPPLY_OK,
    input wire SLEW_OPEN,
    input wire SERIES_FET_ON,
    input wire FET_ON,
    input wire SLOW_TURNOFF,
    input wire AUX_5V_RAIL_EN,
    input wire NEGATIVE_RAIL_EN,
    input wire ERROR_REPORT_N,
    input wire CURRENT_ALARM_N,
    input wire CURRENT_ALARM_OE
);
    reg seen_on; // series fet seen on since reset
    // start-up tracker; sync delay keeps the error low a little longer
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            seen_on <= 1'b0;
        end else if (SERIES_FET_ON) begin
            seen_on <= 1'b1;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // slow current rise with the gate high and nothing else wrong
    sequence s_oc_held;
        (GATE_COMMAND && OC_DETECT && !SC_DETECT && SUPPLY_OK && !FET_OT_HOT
            && !DRV_OT_HOT && seen_on)[*8];
    endsequence
    // gate falls while only the fet die is hot
    sequence s_emul_fall;
        (FET_OT_HOT && !DRV_OT_HOT && SUPPLY_OK)[*6] ##0 $fell(GATE_COMMAND);
    endsequence
    a_oc_alarm: assert property (
        s_oc_held ##0 CURRENT_ALARM_OE |-> !CURRENT_ALARM_N && !FET_ON)
        else $error("overcurrent not flagged or fet left on");
    a_oc_clear: assert property (
        (!GATE_COMMAND && !SLOW_TURNOFF)[*6] ##0 CURRENT_ALARM_OE |-> CURRENT_ALARM_N)
        else $error("current alarm stuck after gate low");
    a_short_off: assert property (SLOW_TURNOFF[*2] |-> !FET_ON)
        else $error("fet on while short latched");
    a_short_pair: assert property (
        SLOW_TURNOFF[*3] ##0 CURRENT_ALARM_OE |-> !ERROR_REPORT_N && !CURRENT_ALARM_N)
        else $error("short not shown as both pins low");
    a_drv_hot: assert property (
        DRV_OT_HOT[*5] |-> !AUX_5V_RAIL_EN && !NEGATIVE_RAIL_EN && !FET_ON)
        else $error("driver overheat left rails or fet on");
    a_thermal_err: assert property ((FET_OT_HOT || DRV_OT_HOT)[*5] |-> !ERROR_REPORT_N)
        else $error("error pin high while hot");
    a_supply_low: assert property ((!SUPPLY_OK)[*5] |-> !FET_ON && !ERROR_REPORT_N)
        else $error("supply low not handled");
    a_slew_err: assert property (SLEW_OPEN[*5] |-> !ERROR_REPORT_N)
        else $error("error pin high with slew pin open");
    a_start_err: assert property (!seen_on |-> !ERROR_REPORT_N)
        else $error("error pin high before start-up done");
    a_emul_blank: assert property (s_emul_fall |-> ##4 (!FET_ON)[*2])
        else $error("fet on during blanking");
endmodule

bind psf_fault_logic psf_fault_logic_assertions u_chk (
    .CLK(CLK), .RST_N(RST_N), .GATE_COMMAND(GATE_COMMAND), .OC_DETECT(OC_DETECT),
    .SC_DETECT(SC_DETECT), .FET_OT_HOT(FET_OT_HOT), .DRV_OT_HOT(DRV_OT_HOT),
    .SUPPLY_OK(SUPPLY_OK), .SLEW_OPEN(SLEW_OPEN), .SERIES_FET_ON(SERIES_FET_ON),
    .FET_ON(FET_ON), .SLOW_TURNOFF(SLOW_TURNOFF), .AUX_5V_RAIL_EN(AUX_5V_RAIL_EN),
    .NEGATIVE_RAIL_EN(NEGATIVE_RAIL_EN), .ERROR_REPORT_N(ERROR_REPORT_N),
    .CURRENT_ALARM_N(CURRENT_ALARM_N), .CURRENT_ALARM_OE(CURRENT_ALARM_OE));

//--- sim/psf_ctrl_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// converter controller driving the gate
// ----------------------------------------
module psf_ctrl_model (
    input wire clk,
    input wire rst_n,
    input wire run, // free-running pwm
    input wire slow, // long pwm phases
    input wire man_gate, // gate level while not running
    input wire ignore_alm, // combined reporting strapped
    input wire err_n,
    input wire alm_n,
    output wire gate
);
    reg [4:0] cnt; // phase length counter
    reg phase; // pwm level
    wire short_seen; // both pins low: latched short
    assign short_seen = !err_n && !alm_n && !ignore_alm;
    // pwm; a reported short parks the gate low so the latch can let go
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 5'h00;
            phase <= 1'b0;
        end else if (!run || short_seen) begin
            cnt <= 5'h00;
            phase <= 1'b0;
        end else if (cnt == (slow ? 5'h1F : 5'h05)) begin
            cnt <= 5'h00;
            phase <= ~phase;
        end else begin
            cnt <= cnt + 5'h01;
        end
    end
    assign gate = run ? phase : man_gate;
endmodule

//--- sim/tb_power_switch_fault_logic.sv
`timescale 1ns/100ps
`include "psf_consts.vh"
module tb_power_switch_fault_logic;
    // ----------------------------------------
    // stimulus, wires and counters
    // ----------------------------------------
    localparam integer LOW_NS = 2000; // shortened latch release time
    localparam integer LOWC = LOW_NS / 50; // same, in cycles
    reg clk = 1'b0, rst_n = 1'b0, gate_man = 1'b0, run = 1'b0, slow = 1'b0, ign = 1'b0;
    reg oc = 1'b0, sc = 1'b0, fh = 1'b0, dh = 1'b0, sup = 1'b1, slew = 1'b0;
    reg ser = 1'b0, dneg = 1'b0, fq = 1'b0, strap = 1'b0;
    reg [3:0] awaddr = 4'h0, araddr = 4'h0;
    reg [31:0] wdata = 32'h0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire gate, fet_on, slow_off, aux_en, neg_en, err_n, alm_n, alm_oe, alm_pin;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer failures = 0, check_count = 0, cyc = 0, i;
    reg [31:0] rd;
    reg [1:0] rs;
    reg [7:0] rows [0:6]; // {sup,fet hot,drv hot,slew,check rails,err,alarm,rails}
    // strap grounded, else the alarm pin reads the design's level while driven, high while released
    assign alm_pin = strap ? 1'b0 : (alm_oe ? alm_n : 1'b1);
    psf_fault_logic #(.SC_RESET_LOW_NS(LOW_NS)) u_psf_fault_logic (
        .CLK(clk), .RST_N(rst_n), .GATE_COMMAND(gate), .OC_DETECT(oc), .SC_DETECT(sc),
        .FET_OT_HOT(fh), .DRV_OT_HOT(dh), .SUPPLY_OK(sup), .SLEW_OPEN(slew),
        .SERIES_FET_ON(ser), .DRAIN_NEGATIVE(dneg), .FIRST_QUADRANT(fq),
        .ALARM_PIN_IN(alm_pin), .FET_ON(fet_on), .SLOW_TURNOFF(slow_off),
        .AUX_5V_RAIL_EN(aux_en), .NEGATIVE_RAIL_EN(neg_en), .ERROR_REPORT_N(err_n),
        .CURRENT_ALARM_N(alm_n), .CURRENT_ALARM_OE(alm_oe), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF),
        .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
    psf_ctrl_model u_psf_ctrl_model (
        .clk(clk), .rst_n(rst_n), .run(run), .slow(slow), .man_gate(gate_man),
        .ignore_alm(ign), .err_n(err_n), .alm_n(alm_n), .gate(gate));
    // ----------------------------------------
    // clock, hang guard and helpers
    // ----------------------------------------
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin // whole run needs well under this
            failures = failures + 1;
            give_verdict;
        end
    end
    task chk(input [35:0] seen, input [35:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d, failures %0d", check_count, failures);
            if (failures == 0 && check_count > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // one bus access; readies sampled between edges, so no edge race
    task axi(input wr, input [3:0] a, input [31:0] d);
        reg ta, tw, tr, tb;
        begin
            @(posedge clk);
            awaddr <= a; araddr <= a; wdata <= d;
            awvalid <= wr; wvalid <= wr; bready <= wr; arvalid <= !wr; rready <= !wr;
            tb = 1'b0;
            while (!tb) begin
                @(negedge clk);
                ta = awready; tw = wready; tr = arready;
                tb = wr ? bvalid : rvalid;
                rs = wr ? bresp : rresp;
                rd = rdata;
                @(posedge clk);
                if (ta) awvalid <= 1'b0;
                if (tw) wvalid <= 1'b0;
                if (tr) arvalid <= 1'b0;
            end
            bready <= 1'b0;
            rready <= 1'b0;
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rows[0] = 8'h8F; rows[1] = 8'hCB; rows[2] = 8'hEA; rows[3] = 8'hAA;
        rows[4] = 8'h9B; rows[5] = 8'h02; rows[6] = 8'h8F;
        tick(16); rst_n <= 1'b1; tick(4); @(negedge clk);
        chk(err_n, 1'b0);
        tick(1);
        ser <= 1'b1;
        tick(8);
        @(negedge clk);
        chk({err_n, alm_n, aux_en}, 3'h7);
        // status levels, one row per fault state
        for (i = 0; i < 7; i = i + 1) begin
            tick(1);
            {sup, fh, dh, slew} <= rows[i][7:4];
            tick(8);
            @(negedge clk);
            chk({err_n, alm_n, fet_on}, {rows[i][2:1], 1'b0});
            if (rows[i][3]) chk({aux_en, neg_en}, {2{rows[i][0]}});
        end
        // overcurrent, cleared by gate low
        tick(1); gate_man <= 1'b1; tick(6); @(negedge clk);
        chk(fet_on, 1'b1);
        tick(1); oc <= 1'b1; tick(8); @(negedge clk);
        chk({err_n, alm_n, fet_on}, 3'h4);
        tick(1); gate_man <= 1'b0; oc <= 1'b0; tick(6); @(negedge clk);
        chk(alm_n, 1'b1);
        // short wins the race; low time too short, then partner releases
        tick(1); gate_man <= 1'b1; tick(6); sc <= 1'b1; oc <= 1'b1; tick(8); @(negedge clk);
        chk({err_n, alm_n, fet_on, slow_off}, 4'h1);
        tick(1); sc <= 1'b0; oc <= 1'b0; gate_man <= 1'b0;
        tick(LOWC - 10); gate_man <= 1'b1; tick(6); @(negedge clk);
        chk({fet_on, slow_off}, 2'h1);
        tick(1); gate_man <= 1'b0; run <= 1'b1; slow <= 1'b1; tick(20); @(negedge clk);
        chk(slow_off, 1'b1);
        for (i = 0; i < 200 && slow_off !== 1'b0; i = i + 1) @(negedge clk);
        chk({err_n, alm_n, slow_off}, 3'h6);
        for (i = 0; i < 200 && fet_on !== 1'b1; i = i + 1) @(negedge clk);
        chk(fet_on, 1'b1);
        // latch cleared over the bus
        tick(1); run <= 1'b0; gate_man <= 1'b1; tick(4); sc <= 1'b1; tick(6);
        sc <= 1'b0; gate_man <= 1'b0;
        axi(1'b0, `PSF_REG_STATUS, 32'h0);
        chk(rd[`PSF_ST_SC], 1'b1);
        axi(1'b1, `PSF_REG_CTRL, 32'h3);
        chk(rs, `PSF_RESP_OKAY);
        axi(1'b0, `PSF_REG_STATUS, 32'h0);
        chk(rd[`PSF_ST_SC], 1'b0);
        axi(1'b0, 4'hC, 32'h0);
        chk({rs, rd}, {`PSF_RESP_SLVERR, 32'h0});
        // diode emulation on a hot fet die
        tick(1); fh <= 1'b1; tick(8); dneg <= 1'b1; tick(6); @(negedge clk);
        chk(fet_on, 1'b0); // forced off over the bus
        axi(1'b1, `PSF_REG_CTRL, 32'h0); tick(2); @(negedge clk);
        chk(fet_on, 1'b1);
        tick(1); dneg <= 1'b0; fq <= 1'b1; tick(6); @(negedge clk);
        chk(fet_on, 1'b0);
        tick(1); fq <= 1'b0; dh <= 1'b1; dneg <= 1'b1; tick(6); @(negedge clk);
        chk({fet_on, aux_en, err_n}, 3'h0);
        tick(1); dh <= 1'b0; tick(8); @(negedge clk);
        chk(fet_on, 1'b1);
        tick(1); gate_man <= 1'b1; tick(4); gate_man <= 1'b0; tick(4); @(negedge clk);
        chk(fet_on, 1'b0);
        tick(8); @(negedge clk);
        chk(fet_on, 1'b1);
        // second reset with the alarm pin strapped low
        tick(1); fh <= 1'b0; dneg <= 1'b0; strap <= 1'b1; ign <= 1'b1; rst_n <= 1'b0;
        tick(4); rst_n <= 1'b1; tick(8); @(negedge clk);
        chk(alm_oe, 1'b0);
        tick(1); gate_man <= 1'b1; tick(5); oc <= 1'b1; tick(8); @(negedge clk);
        chk({err_n, fet_on}, 2'h0);
        tick(1); oc <= 1'b0; gate_man <= 1'b0; tick(6); @(negedge clk);
        chk(err_n, 1'b1);
        give_verdict;
    end
endmodule
